// [design/dpcu_params.svh]
// Operation
// - a write to the command port starts a command without touching the shared command block
// - bits 31:4 carry an aligned host pointer, bits 3:0 the function code
// - byte writes take effect only once the top byte has been written
// - codes 0000 reset, 0001 self-test, 0010 selective, 0011 dump, 0111 wake-up dump
// - every command causes an internal selective or complete reset
// - a complete reset clears the control/status space and bus-master state
// - selective reset idles command and receive units and keeps configuration
// - self-test starts with selective reset, tests rom, registers, engine, writes results
// - rom words go through an lfsr; signature and verdict go to memory
// - every parallel register is written, read back and checked
// - a diagnose command goes to the serial subsystem and its verdict is kept
// - result word: overall bit 12, diagnose 5, registers 3, rom 2, 1 is fail
// - after self-test results, full internal reset and no completion indication
// - dump copies internal state and finishes with 0xA006 at dword 149
// - wake-up dump writes byte count at dword 1, 0xFF and 120 bytes if longer
// - packet bytes follow from dword 2, then 0xA000 into dword 0 last
`ifndef DPCU_PARAMS_SVH
`define DPCU_PARAMS_SVH
`define DPCU_PORT_OFS      4'h8
`define DPCU_TOP_LANE      3
`define DPCU_PTR_LSB       4
`define DPCU_FN_SWRESET    4'h0
`define DPCU_FN_SELFTEST   4'h1
`define DPCU_FN_SELRESET   4'h2
`define DPCU_FN_DUMP       4'h3
`define DPCU_FN_WAKEDUMP   4'h7
`define DPCU_DUMP_LAST     8'h95
`define DPCU_DUMP_DONE     32'h0000_A006
`define DPCU_WAKE_DONE     32'h0000_A000
`define DPCU_WAKE_MAX      11'h078
`define DPCU_WAKE_OVER     8'hFF
`define DPCU_WAKE_CNT_DW   8'h01
`define DPCU_WAKE_DAT_DW   8'h02
`define DPCU_ST_OVERALL    12
`define DPCU_ST_DIAG       5
`define DPCU_ST_REGS       3
`define DPCU_ST_ROM        2
`define DPCU_LFSR_SEED     32'hFFFF_FFFF
`define DPCU_LFSR_POLY     32'h04C1_1DB7
`define DPCU_PAT_A         16'h5555
`define DPCU_PAT_B         16'hAAAA
`endif

// [design/dpcu_pkg.sv]
package dpcu_pkg;
    typedef enum logic [3:0] {
        DPCU_IDLE,
        DPCU_ST_ROM,
        DPCU_ST_REG,
        DPCU_ST_DIAG,
        DPCU_ST_SIG,
        DPCU_ST_RES,
        DPCU_DMP_DAT,
        DPCU_DMP_END,
        DPCU_WK_CNT,
        DPCU_WK_DAT,
        DPCU_WK_STAT,
        DPCU_FIN
    } dpcu_state_t;
    typedef logic [31:0] dpcu_word_t;
endpackage

// [design/dpcu_step_if.sv]
`timescale 1ns/10ps
interface dpcu_step_if;
    logic start;
    logic done;
    logic fail;
    modport ctl  (output start, input done, input fail);
    modport unit (input start, output done, output fail);
endinterface

// [design/dpcu_rom_sig.sv]
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_rom_sig #(
    parameter int         ROM_AW   = 8,
    parameter logic [31:0] GOOD_SIG = 32'h0000_0000
) (
    input  wire logic              clk,
    input  wire logic              reset,
    dpcu_step_if.unit              step,
    output logic [ROM_AW-1:0]      rom_addr,
    input  wire logic [31:0]       rom_data,
    output dpcu_pkg::dpcu_word_t   signature
);
    import dpcu_pkg::*;
    logic              run_reg;
    logic              last_reg;
    logic [31:0]       mix;

    always_comb begin
        mix = signature ^ rom_data;
        mix = mix[31] ? ((mix << 1) ^ `DPCU_LFSR_POLY) : (mix << 1);
    end

    // every rom word in order, data used in the same cycle as its address
    always_ff @(posedge clk) begin
        step.done <= 1'b0;
        if (reset) begin
            run_reg   <= 1'b0;
            last_reg  <= 1'b0;
            rom_addr  <= '0;
            signature <= `DPCU_LFSR_SEED;
            step.fail <= 1'b0;
        end else if (step.start) begin
            run_reg   <= 1'b1;
            last_reg  <= 1'b0;
            rom_addr  <= '0;
            signature <= `DPCU_LFSR_SEED;
        end else if (run_reg && last_reg) begin
            run_reg   <= 1'b0;
            step.done <= 1'b1;
            step.fail <= (signature != GOOD_SIG);
        end else if (run_reg) begin
            signature <= mix;
            rom_addr  <= rom_addr + 1'b1;
            last_reg  <= &rom_addr;
        end
    end
endmodule

// [design/dpcu_reg_test.sv]
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_reg_test #(
    parameter int NREG = 16
) (
    input  wire logic clk,
    input  wire logic reset,
    dpcu_step_if.unit step
);
    import dpcu_pkg::*;
    localparam int IW = $clog2(NREG);
    logic [15:0]   bank [NREG];
    logic [IW-1:0] idx_reg;
    logic [1:0]    phase_reg;
    logic          run_reg;
    logic [15:0]   pat;

    assign pat = phase_reg[1] ? `DPCU_PAT_B : `DPCU_PAT_A;

    // phase 0/2 writes a pattern, 1/3 reads it back
    always_ff @(posedge clk) begin
        step.done <= 1'b0;
        if (reset) begin
            run_reg   <= 1'b0;
            idx_reg   <= '0;
            phase_reg <= 2'd0;
            step.fail <= 1'b0;
        end else if (step.start) begin
            run_reg   <= 1'b1;
            idx_reg   <= '0;
            phase_reg <= 2'd0;
            step.fail <= 1'b0;
        end else if (run_reg) begin
            if (!phase_reg[0]) begin
                bank[idx_reg] <= pat;
            end else if (bank[idx_reg] != pat) begin
                step.fail <= 1'b1;
            end
            if (idx_reg == IW'(NREG - 1)) begin
                idx_reg   <= '0;
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd3) begin
                    run_reg   <= 1'b0;
                    step.done <= 1'b1;
                end
            end else begin
                idx_reg <= idx_reg + 1'b1;
            end
        end
    end
endmodule

// [design/dpcu_core.sv]
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_core #(
    parameter int          ROM_AW   = 8,
    parameter int          NREG     = 16,
    parameter logic [31:0] GOOD_SIG = 32'h0000_0000
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                csr_wr,
    input  wire logic [3:0]          csr_addr,
    input  wire logic [3:0]          csr_be,
    input  wire logic [31:0]         csr_wdata,
    output logic                     busy,
    output logic                     complete_reset,
    output logic                     selective_reset,
    output logic                     mem_req,
    output logic [31:0]              mem_addr,
    output dpcu_pkg::dpcu_word_t     mem_data,
    input  wire logic                mem_ack,
    output logic [ROM_AW-1:0]        rom_addr,
    input  wire logic [31:0]         rom_data,
    output logic                     diag_req,
    input  wire logic                diag_done,
    input  wire logic                diag_fail,
    output logic [7:0]               dump_idx,
    input  wire logic [31:0]         dump_data,
    input  wire logic [10:0]         wake_len,
    output logic [4:0]               wake_idx,
    input  wire logic [31:0]         wake_data
);
    import dpcu_pkg::*;

    dpcu_step_if rom_step ();
    dpcu_step_if reg_step ();

    dpcu_state_t state_reg;
    logic [31:0] port_reg;
    logic [31:0] port_next;
    logic        go;
    logic        int_reset;
    logic [31:0] ptr_reg;
    logic        rom_fail_reg;
    logic        reg_fail_reg;
    logic        diag_fail_reg;
    logic [31:0] sig;
    logic        end_complete_reg;
    logic [10:0] posted;
    logic [7:0]  wake_cnt;
    logic [4:0]  wake_last;
    logic [31:0] st_word;

    // a complete reset also clears this block
    assign int_reset = reset | complete_reset;
    assign busy      = (state_reg != DPCU_IDLE);

    dpcu_rom_sig #(
        .ROM_AW   (ROM_AW),
        .GOOD_SIG (GOOD_SIG)
    ) u_rom (
        .clk       (clk),
        .reset     (int_reset),
        .step      (rom_step.unit),
        .rom_addr  (rom_addr),
        .rom_data  (rom_data),
        .signature (sig)
    );

    dpcu_reg_test #(
        .NREG (NREG)
    ) u_regs (
        .clk   (clk),
        .reset (int_reset),
        .step  (reg_step.unit)
    );

    // byte lanes merge into the staged word
    always_comb begin
        port_next = port_reg;
        for (int i = 0; i < 4; i++) begin
            if (csr_be[i]) begin
                port_next[8*i +: 8] = csr_wdata[8*i +: 8];
            end
        end
    end

    // only a write that covers the top lane fires the command
    assign go = csr_wr && (csr_addr == `DPCU_PORT_OFS)
                && csr_be[`DPCU_TOP_LANE] && !busy;

    always_ff @(posedge clk) begin
        if (int_reset) begin
            port_reg <= '0;
        end else if (csr_wr && csr_addr == `DPCU_PORT_OFS) begin
            port_reg <= port_next;
        end
    end

    // wake-up packet: clip to 120 bytes, count FFh when clipped
    assign posted    = (wake_len > `DPCU_WAKE_MAX) ? `DPCU_WAKE_MAX : wake_len;
    assign wake_cnt  = (wake_len > `DPCU_WAKE_MAX) ? `DPCU_WAKE_OVER : wake_len[7:0];
    assign wake_last = 5'((posted + 11'd3) >> 2) - 5'd1;

    // result word, 1 means fail
    always_comb begin
        st_word                   = '0;
        st_word[`DPCU_ST_ROM]     = rom_fail_reg;
        st_word[`DPCU_ST_REGS]    = reg_fail_reg;
        st_word[`DPCU_ST_DIAG]    = diag_fail_reg;
        st_word[`DPCU_ST_OVERALL] = rom_fail_reg | reg_fail_reg | diag_fail_reg;
    end

    // rom, register and diagnose verdicts
    always_ff @(posedge clk) begin
        if (int_reset) begin
            rom_fail_reg  <= 1'b0;
            reg_fail_reg  <= 1'b0;
            diag_fail_reg <= 1'b0;
        end else begin
            if (rom_step.done) begin
                rom_fail_reg <= rom_step.fail;
            end
            if (reg_step.done) begin
                reg_fail_reg <= reg_step.fail;
            end
            if (state_reg == DPCU_ST_DIAG && diag_done) begin
                diag_fail_reg <= diag_fail;
            end
        end
    end

    // reset pulses; self-test opens with a selective one
    always_ff @(posedge clk) begin
        if (reset) begin
            complete_reset  <= 1'b0;
            selective_reset <= 1'b0;
        end else begin
            complete_reset  <= 1'b0;
            selective_reset <= 1'b0;
            if (go && port_next[3:0] == `DPCU_FN_SWRESET) begin
                complete_reset <= 1'b1;
            end else if (go && port_next[3:0] == `DPCU_FN_SELRESET) begin
                selective_reset <= 1'b1;
            end else if (go && port_next[3:0] == `DPCU_FN_SELFTEST) begin
                selective_reset <= 1'b1;
            end else if (state_reg == DPCU_FIN) begin
                complete_reset  <= end_complete_reg;
                selective_reset <= !end_complete_reg;
            end
        end
    end

    // function sequencer and host memory writes
    always_ff @(posedge clk) begin
        rom_step.start <= 1'b0;
        reg_step.start <= 1'b0;
        if (int_reset) begin
            state_reg        <= DPCU_IDLE;
            ptr_reg          <= '0;
            mem_req          <= 1'b0;
            mem_addr         <= '0;
            mem_data         <= '0;
            diag_req         <= 1'b0;
            dump_idx         <= '0;
            wake_idx         <= '0;
            end_complete_reg <= 1'b0;
        end else begin
            case (state_reg)
                DPCU_IDLE: begin
                    ptr_reg  <= {port_next[31:`DPCU_PTR_LSB], 4'h0};
                    dump_idx <= '0;
                    wake_idx <= '0;
                    if (go) begin
                        case (port_next[3:0])
                            `DPCU_FN_SELFTEST: begin
                                state_reg        <= DPCU_ST_ROM;
                                rom_step.start   <= 1'b1;
                                end_complete_reg <= 1'b1;
                            end
                            `DPCU_FN_DUMP: begin
                                state_reg        <= DPCU_DMP_DAT;
                                end_complete_reg <= 1'b0;
                            end
                            `DPCU_FN_WAKEDUMP: begin
                                state_reg        <= DPCU_WK_CNT;
                                end_complete_reg <= 1'b0;
                            end
                            default: begin
                                state_reg <= DPCU_IDLE;
                            end
                        endcase
                    end
                end
                DPCU_ST_ROM: begin
                    if (rom_step.done) begin
                        state_reg      <= DPCU_ST_REG;
                        reg_step.start <= 1'b1;
                    end
                end
                DPCU_ST_REG: begin
                    if (reg_step.done) begin
                        state_reg <= DPCU_ST_DIAG;
                        diag_req  <= 1'b1;
                    end
                end
                DPCU_ST_DIAG: begin
                    if (diag_done) begin
                        diag_req  <= 1'b0;
                        state_reg <= DPCU_ST_SIG;
                    end
                end
                DPCU_ST_SIG: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= ptr_reg;
                        mem_data <= sig;
                    end else if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= DPCU_ST_RES;
                    end
                end
                DPCU_ST_RES: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= ptr_reg + 32'h0000_0004;
                        mem_data <= st_word;
                    end else if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= DPCU_FIN;
                    end
                end
                DPCU_DMP_DAT: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= ptr_reg + {22'h0, dump_idx, 2'b00};
                        mem_data <= dump_data;
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        if (dump_idx == `DPCU_DUMP_LAST - 8'h01) begin
                            state_reg <= DPCU_DMP_END;
                        end else begin
                            dump_idx <= dump_idx + 8'h01;
                        end
                    end
                end
                DPCU_DMP_END: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= ptr_reg + {22'h0, `DPCU_DUMP_LAST, 2'b00};
                        mem_data <= `DPCU_DUMP_DONE;
                    end else if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= DPCU_FIN;
                    end
                end
                DPCU_WK_CNT: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= ptr_reg + {22'h0, `DPCU_WAKE_CNT_DW, 2'b00};
                        mem_data <= {24'h0, wake_cnt};
                    end else if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= (posted == 11'h000) ? DPCU_WK_STAT : DPCU_WK_DAT;
                    end
                end
                DPCU_WK_DAT: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= ptr_reg
                                    + {22'h0, `DPCU_WAKE_DAT_DW + {3'b000, wake_idx}, 2'b00};
                        mem_data <= wake_data;
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        if (wake_idx == wake_last) begin
                            state_reg <= DPCU_WK_STAT;
                        end else begin
                            wake_idx <= wake_idx + 5'd1;
                        end
                    end
                end
                DPCU_WK_STAT: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= ptr_reg;
                        mem_data <= `DPCU_WAKE_DONE;
                    end else if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= DPCU_FIN;
                    end
                end
                DPCU_FIN: begin
                    state_reg <= DPCU_IDLE;
                end
                default: begin
                    state_reg <= DPCU_IDLE;
                end
            endcase
        end
    end
endmodule

// [dv/dpcu_core_monitor.sv]
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_core_monitor #(
    parameter int ROM_AW = 8
) (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 csr_wr,
    input wire logic [3:0]           csr_addr,
    input wire logic [3:0]           csr_be,
    input wire logic [31:0]          csr_wdata,
    input wire logic                 busy,
    input wire logic                 complete_reset,
    input wire logic                 selective_reset,
    input wire logic                 mem_req,
    input wire logic [31:0]          mem_addr,
    input wire dpcu_pkg::dpcu_word_t mem_data,
    input wire logic                 mem_ack
);
    import dpcu_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic        fire;
    logic [3:0]  fn;
    logic [31:0] shadow_reg;
    logic [31:0] staged;
    // staged command word, merged per byte lane
    always_comb begin
        staged = shadow_reg;
        for (int i = 0; i < 4; i++) begin
            if (csr_be[i]) begin
                staged[8*i +: 8] = csr_wdata[8*i +: 8];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (reset || complete_reset) begin
            shadow_reg <= '0;
        end else if (csr_wr && csr_addr == `DPCU_PORT_OFS) begin
            shadow_reg <= staged;
        end
    end
    assign fn = staged[3:0];
    assign fire = csr_wr && csr_addr == `DPCU_PORT_OFS && csr_be[`DPCU_TOP_LANE] && !busy;
    sequence s_full;
        complete_reset && !busy ##1 !complete_reset;
    endsequence
    sequence s_sel;
        selective_reset && !complete_reset && !busy ##1 !selective_reset;
    endsequence
    property p_swreset;
        fire && fn == `DPCU_FN_SWRESET |=> s_full;
    endproperty
    property p_selreset;
        fire && fn == `DPCU_FN_SELRESET |=> s_sel;
    endproperty
    property p_selftest;
        fire && fn == `DPCU_FN_SELFTEST |=> busy && selective_reset;
    endproperty
    property p_dumps;
        fire && (fn == `DPCU_FN_DUMP || fn == `DPCU_FN_WAKEDUMP) |=> busy && !complete_reset;
    endproperty
    property p_bad_code;
        fire && !(fn inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h7})
            |=> !busy && !complete_reset && !selective_reset && !mem_req;
    endproperty
    property p_low_bytes;
        csr_wr && !csr_be[`DPCU_TOP_LANE] && !busy
            |=> !busy && !complete_reset && !selective_reset;
    endproperty
    property p_mem_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_data);
    endproperty
    property p_mem_gap;
        mem_req && mem_ack |=> !mem_req;
    endproperty
    property p_idle_quiet;
        !busy |-> !mem_req;
    endproperty
    property p_end_reset;
        $fell(busy) |-> ##[0:1] (selective_reset || complete_reset);
    endproperty
    a_swreset: assert property (p_swreset)
        else $error("no complete reset pulse after code 0");
    a_selreset: assert property (p_selreset)
        else $error("no selective reset pulse after code 2");
    a_selftest: assert property (p_selftest)
        else $error("self-test did not start with selective reset");
    a_dumps: assert property (p_dumps)
        else $error("dump command did not start");
    a_bad_code: assert property (p_bad_code)
        else $error("unsupported code had an effect");
    a_low_bytes: assert property (p_low_bytes)
        else $error("command fired without top byte");
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory request changed before ack");
    a_mem_gap: assert property (p_mem_gap)
        else $error("memory request not dropped after ack");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("memory write while idle");
    a_end_reset: assert property (p_end_reset)
        else $error("command ended without internal reset");
endmodule
bind dpcu_core dpcu_core_monitor #(.ROM_AW(ROM_AW)) mon_u (
    .clk(clk), .reset(reset), .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_be(csr_be),
    .csr_wdata(csr_wdata), .busy(busy), .complete_reset(complete_reset),
    .selective_reset(selective_reset), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_ack(mem_ack)
);

// [dv/dpcu_host_model.sv]
`timescale 1ns/10ps
module dpcu_host_model (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 mem_req,
    input wire logic [31:0]          mem_addr,
    input wire dpcu_pkg::dpcu_word_t mem_data,
    input wire logic [3:0]           ack_dly,
    output logic                     mem_ack
);
    import dpcu_pkg::*;
    logic [31:0] mem [logic [31:0]];
    logic [31:0] last_addr;
    int          nwr = 0;
    int          cnt;
    // write lands only on the edge that sees req and ack together
    always @(posedge clk) begin
        if (reset) begin
            mem_ack <= 1'b0;
            cnt <= 0;
        end else if (mem_req && mem_ack) begin
            mem[mem_addr] = mem_data;
            last_addr <= mem_addr;
            nwr <= nwr + 1;
            mem_ack <= 1'b0;
        end else if (mem_req && cnt >= int'(ack_dly)) begin
            mem_ack <= 1'b1;
            cnt <= 0;
        end else if (mem_req) begin
            cnt <= cnt + 1;
        end
    end
endmodule

// [dv/dpcu_core_tb.sv]
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_core_tb;
    import dpcu_pkg::*;
    logic        clk, reset, csr_wr, busy, complete_reset, selective_reset;
    logic        mem_req, mem_ack, diag_req, diag_done, diag_fail;
    logic [3:0]  csr_addr, csr_be, ack_dly, rom_addr;
    logic [31:0] csr_wdata, mem_addr, rom_data, dump_data, wake_data, ptr, ex;
    dpcu_word_t  mem_data;
    logic [7:0]  dump_idx;
    logic [10:0] wake_len;
    logic [4:0]  wake_idx;
    int          error_cnt = 0, num_checks = 0, cyc = 0, n0, nb, nw;
    logic [3:0]  bad_codes [5] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'hF};
    logic [10:0] wake_lens [4] = '{11'h082, 11'h005, 11'h078, 11'h000};
    logic        diag_vals [2] = '{1'b1, 1'b0};
    // reference signature of the 16-word test rom pattern
    function automatic logic [31:0] lfsr_ref();
        logic [31:0] s;
        s = `DPCU_LFSR_SEED;
        for (int k = 0; k < 16; k++) begin
            s = s ^ (32'h0F0F_0000 | 32'(k));
            s = s[31] ? ((s << 1) ^ `DPCU_LFSR_POLY) : (s << 1);
        end
        return s;
    endfunction
    localparam logic [31:0] ROM_SIG = lfsr_ref();
    assign rom_data = 32'h0F0F_0000 | {28'h000_0000, rom_addr};
    assign dump_data = 32'hD000_0000 | {24'h00_0000, dump_idx};
    assign wake_data = 32'hBE00_0000 | {27'h000_0000, wake_idx};
    dpcu_core #(.ROM_AW(4), .NREG(4), .GOOD_SIG(ROM_SIG)) dut_u (
        .clk(clk), .reset(reset), .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_be(csr_be),
        .csr_wdata(csr_wdata), .busy(busy), .complete_reset(complete_reset),
        .selective_reset(selective_reset), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_data(mem_data), .mem_ack(mem_ack), .rom_addr(rom_addr), .rom_data(rom_data),
        .diag_req(diag_req), .diag_done(diag_done), .diag_fail(diag_fail),
        .dump_idx(dump_idx), .dump_data(dump_data), .wake_len(wake_len),
        .wake_idx(wake_idx), .wake_data(wake_data)
    );
    dpcu_host_model host_u (
        .clk(clk), .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_data(mem_data), .ack_dly(ack_dly), .mem_ack(mem_ack)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("timeout at %0t", $time);
            summarize();
        end
    end
    // serial subsystem answers in the same cycle as the request
    always @(posedge clk) begin
        #1;
        diag_done = diag_req && !diag_done;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic csr_write(input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1;
        csr_wr = 1'b1;
        csr_addr = `DPCU_PORT_OFS;
        csr_be = be;
        csr_wdata = d;
        @(posedge clk);
        #1;
        csr_wr = 1'b0;
    endtask
    task automatic wait_idle();
        while (busy !== 1'b0) @(posedge clk);
        repeat (12) @(posedge clk);
    endtask
    function automatic logic [31:0] flags();
        return {29'h0000_0000, complete_reset, selective_reset, busy};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        {csr_wr, csr_addr, csr_be, csr_wdata, ack_dly, wake_len} = '0;
        diag_done = 1'b0;
        diag_fail = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        reset = 1'b0;
        csr_write(4'hF, {28'h000_0000, `DPCU_FN_SWRESET});
        check(flags(), 32'h0000_0004);
        wait_idle();
        csr_write(4'hF, {28'h123_4567, `DPCU_FN_SELRESET});
        check(flags(), 32'h0000_0002);
        wait_idle();
        $display("test resets done");
        csr_write(4'h1, 32'h0000_0002);
        csr_write(4'h2, 32'h0000_0000);
        csr_write(4'h4, 32'h0000_0000);
        check(flags(), 32'h0000_0000);
        csr_write(4'h8, 32'h0000_0000);
        check(flags(), 32'h0000_0002);
        wait_idle();
        foreach (bad_codes[i]) begin
            csr_write(4'hF, {28'h000_0000, bad_codes[i]});
            ex = flags();
            check({ex[30:0], mem_req}, 32'h0000_0000);
        end
        $display("test byte lanes and bad codes done");
        ack_dly = 4'h2;
        ptr = 32'h0001_0000;
        n0 = host_u.nwr;
        csr_write(4'hF, ptr | 32'h0000_0003);
        wait_idle();
        check(32'(host_u.nwr - n0), 32'h0000_0096);
        check(host_u.mem[ptr], 32'hD000_0000);
        check(host_u.mem[ptr + 32'h0000_0250], 32'hD000_0094);
        check(host_u.mem[ptr + 32'h0000_0254], `DPCU_DUMP_DONE);
        check(host_u.last_addr, ptr + 32'h0000_0254);
        $display("test dump done");
        ack_dly = 4'h0;
        foreach (wake_lens[i]) begin
            wake_len = wake_lens[i];
            ptr = 32'h0002_0000 + 32'(i) * 32'h0000_0100;
            host_u.mem[ptr] = 32'h0000_0000;
            nb = (wake_len > 11'h078) ? 120 : int'(wake_len);
            nw = (nb + 3) / 4;
            csr_write(4'hF, ptr | 32'h0000_0007);
            wait_idle();
            ex = (wake_len > 11'h078) ? 32'h0000_00FF : 32'(nb);
            check(host_u.mem[ptr + 32'h0000_0004], ex);
            if (nw > 0)
                check(host_u.mem[ptr + 32'(4 + 4 * nw)], 32'hBE00_0000 | 32'(nw - 1));
            check(32'(host_u.mem.exists(ptr + 32'(8 + 4 * nw))), 32'h0000_0000);
            check(host_u.mem[ptr], `DPCU_WAKE_DONE);
            check(host_u.last_addr, ptr);
        end
        $display("test wake dump done");
        foreach (diag_vals[i]) begin
            diag_fail = diag_vals[i];
            ptr = 32'h0003_0000 + 32'(i) * 32'h0000_0100;
            csr_write(4'hF, ptr | 32'h0000_0001);
            wait_idle();
            check(host_u.mem[ptr], ROM_SIG);
            ex = {19'h0_0000, diag_fail, 6'h00, diag_fail, 5'h00};
            check(host_u.mem[ptr + 32'h0000_0004], ex);
            check(flags(), 32'h0000_0000);
        end
        $display("test self-test done");
        summarize();
    end
endmodule
